//--- rtl/dbp_unit.sv
// Purpose: Bit manipulation, lane compare and lane select datapath, one cycle
// Assumes: Core holds operands valid with req_valid for one cycle per request
// Notes: Results and flag updates appear one edge after the request is taken
//
// Behaviour
// - Reverse low 16 bits, clear upper half
// - Insert field sized and placed by control word
// - Byte replicate from immediate or register
// - Half replicate from register or sign-extended immediate
// - Byte compare writes only four flags
// - Dual byte compare writes register and flags
// - Register byte compare leaves flags alone
// - Signed halfword compare sets two flags
// - Byte select by four flags
// - Halfword select by two flags
// - Shift_left_merge_op shifts left, fills from first source
// - Shift_right_merge_op shifts right, fills from first source
// - Byte align merges two sources by count
// - Pack one halfword from each source
`timescale 1ns/1ps
module dbp_unit
    import dbp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Request from the core
    input wire logic req_valid,
    input wire dbp_req_s req,
    input wire logic [DBP_WORD_W-1:0] dsp_ctrl_reg,
    input wire logic [DBP_FLAG_W-1:0] flags_in,
    // Result to the core
    output logic res_valid_reg,
    output logic gpr_write_reg,
    output logic [DBP_WORD_W-1:0] gpr_data_reg,
    output logic [DBP_FLAG_W-1:0] flag_write_reg,
    output logic [DBP_FLAG_W-1:0] flag_data_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Reverse the low halfword, upper half forced to zero
    function automatic logic [DBP_WORD_W-1:0] rev_low_half(input logic [DBP_WORD_W-1:0] w);
        logic [DBP_WORD_W-1:0] r;
        r = DBP_WORD_ZERO;
        for (int i = 0; i < DBP_HALF_W; i++)
        begin
            r[i] = w[DBP_HALF_W-1-i];
        end
        return r;
    endfunction

    // Mask of the n lowest bits; n of zero gives an empty mask
    function automatic logic [DBP_WORD_W-1:0] low_mask(input logic [DBP_SHAMT_W-1:0] n);
        logic [DBP_WORD_W:0] m;
        m = ({{DBP_WORD_W{1'b0}}, 1'b1} << n) - {{DBP_WORD_W{1'b0}}, 1'b1};
        return m[DBP_WORD_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Lane compares, lane i drives hit bit i
    logic [DBP_BYTE_LANES-1:0] byte_hit; // Unsigned byte lane results
    logic [DBP_HALF_LANES-1:0] half_hit; // Signed halfword lane results

    genvar g;
    generate
        for (g = 0; g < DBP_BYTE_LANES; g++)
        begin : g_byte
            dbp_lane_cmp #(.LANE_W(DBP_BYTE_W), .IS_SIGNED(1'b0)) u_cmp (
                .lane_a(req.src_a[g*DBP_BYTE_W +: DBP_BYTE_W]),
                .lane_b(req.src_b[g*DBP_BYTE_W +: DBP_BYTE_W]),
                .cond(req.cond),
                .hit(byte_hit[g])
            );
        end
        for (g = 0; g < DBP_HALF_LANES; g++)
        begin : g_half
            dbp_lane_cmp #(.LANE_W(DBP_HALF_W), .IS_SIGNED(1'b1)) u_cmp (
                .lane_a(req.src_a[g*DBP_HALF_W +: DBP_HALF_W]),
                .lane_b(req.src_b[g*DBP_HALF_W +: DBP_HALF_W]),
                .cond(req.cond),
                .hit(half_hit[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Result selection
    logic [DBP_WORD_W-1:0] data_next; // Word for the destination register
    logic gpr_write_next; // Destination register is written
    logic [DBP_FLAG_W-1:0] flag_write_next; // Which flag bits change
    logic [DBP_FLAG_W-1:0] flag_data_next; // New flag values
    logic [DBP_SHAMT_W-1:0] ins_size; // Field size from control word
    logic [DBP_SHAMT_W-1:0] ins_pos; // Field position from control word
    logic [DBP_WORD_W-1:0] ins_mask; // Field mask in place
    logic [2*DBP_WORD_W-1:0] pre_cat; // First source above second for shift_right_merge_op
    logic [2*DBP_WORD_W-1:0] aln_cat; // First source above second for align
    logic [DBP_SHAMT_W-1:0] bcnt_bits; // Align shift in bits, three bytes at most
    logic [DBP_HALF_W-1:0] imm_half; // Immediate sign-extended to a half

    always_comb
    begin
        ins_size = dsp_ctrl_reg[DBP_CTRL_SIZE_MSB:DBP_CTRL_SIZE_LSB];
        ins_pos = dsp_ctrl_reg[DBP_CTRL_POS_MSB:DBP_CTRL_POS_LSB];
        ins_mask = low_mask(ins_size) << ins_pos;
        pre_cat = {req.src_a, req.src_b} >> req.shift_amount;
        // Count bytes of the second source land low, the rest come from the first
        bcnt_bits = DBP_SHAMT_W'(req.byte_count * DBP_BYTE_W);
        aln_cat = {req.src_a, req.src_b} << bcnt_bits;
        imm_half = {{(DBP_HALF_W-DBP_IMM_W){req.imm[DBP_IMM_W-1]}}, req.imm};
        data_next = DBP_WORD_ZERO;
        gpr_write_next = 1'b1;
        flag_write_next = DBP_FLAGS_NONE;
        flag_data_next = DBP_FLAGS_NONE;
        unique case (req.op)
            bit_reverse_op: data_next = rev_low_half(req.src_b);
            variable_field_insert_op:
                // Field bits past bit 31 simply fall off the top
                data_next = ((req.src_a << ins_pos) & ins_mask) | (req.src_b & ~ins_mask);
            byte_replicate_imm_op: data_next = {DBP_BYTE_LANES{req.imm[DBP_BYTE_W-1:0]}};
            byte_replicate_reg_op: data_next = {DBP_BYTE_LANES{req.src_b[DBP_BYTE_W-1:0]}};
            half_replicate_imm_op: data_next = {DBP_HALF_LANES{imm_half}};
            half_replicate_reg_op: data_next = {DBP_HALF_LANES{req.src_b[DBP_HALF_W-1:0]}};
            byte_compare_flags_op:
            begin
                // Flags only, no register write
                gpr_write_next = 1'b0;
                flag_write_next = DBP_FLAGS_BYTE;
                flag_data_next = byte_hit;
            end
            byte_compare_dual_op:
            begin
                data_next = {{(DBP_WORD_W-DBP_FLAG_W){1'b0}}, byte_hit};
                flag_write_next = DBP_FLAGS_BYTE;
                flag_data_next = byte_hit;
            end
            byte_compare_reg_op: data_next = {{(DBP_WORD_W-DBP_FLAG_W){1'b0}}, byte_hit};
            half_compare_flags_op:
            begin
                gpr_write_next = 1'b0;
                flag_write_next = DBP_FLAGS_HALF;
                flag_data_next = {{(DBP_FLAG_W-DBP_HALF_LANES){1'b0}}, half_hit};
            end
            byte_select_op:
                for (int i = 0; i < DBP_BYTE_LANES; i++)
                begin
                    data_next[i*DBP_BYTE_W +: DBP_BYTE_W] = flags_in[i] ?
                        req.src_a[i*DBP_BYTE_W +: DBP_BYTE_W] :
                        req.src_b[i*DBP_BYTE_W +: DBP_BYTE_W];
                end
            half_select_op:
                for (int i = 0; i < DBP_HALF_LANES; i++)
                begin
                    data_next[i*DBP_HALF_W +: DBP_HALF_W] = flags_in[i] ?
                        req.src_a[i*DBP_HALF_W +: DBP_HALF_W] :
                        req.src_b[i*DBP_HALF_W +: DBP_HALF_W];
                end
            shift_left_merge_op:
                data_next = (req.src_b << req.shift_amount)
                    | (req.src_a & low_mask(req.shift_amount));
            shift_right_merge_op: data_next = pre_cat[DBP_WORD_W-1:0];
            byte_align_op: data_next = aln_cat[2*DBP_WORD_W-1:DBP_WORD_W];
            half_pack_op:
                data_next = {req.src_a[DBP_HALF_W-1:0], req.src_b[DBP_WORD_W-1:DBP_HALF_W]};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result registers; write enables drop when no request is taken
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            res_valid_reg <= 1'b0;
            gpr_write_reg <= 1'b0;
            flag_write_reg <= DBP_FLAGS_NONE;
        end
        else
        begin
            res_valid_reg <= req_valid;
            gpr_write_reg <= req_valid & gpr_write_next;
            flag_write_reg <= req_valid ? flag_write_next : DBP_FLAGS_NONE;
        end
    end

    // Data registers load only on a request, holding the last answer otherwise
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gpr_data_reg <= DBP_WORD_ZERO;
            flag_data_reg <= DBP_FLAGS_NONE;
        end
        else if (req_valid)
        begin
            gpr_data_reg <= data_next;
            flag_data_reg <= flag_data_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    function automatic logic took(input dbp_op_e o);
        return req_valid && req.op == o;
    endfunction

    chk_bit_reverse_op_upper: assert property (took(bit_reverse_op) |=> gpr_write_reg
        && gpr_data_reg[31:16] == 16'h0000 && gpr_data_reg[0] == $past(req.src_b[15])
        && gpr_data_reg[15] == $past(req.src_b[0]))
        else $error("bit reverse result wrong");
    chk_byte_flags_only: assert property (took(byte_compare_flags_op) |=>
        !gpr_write_reg && flag_write_reg == 4'hf)
        else $error("byte compare must write flags only");
    chk_dual_match: assert property (took(byte_compare_dual_op) |=> gpr_write_reg
        && flag_write_reg == 4'hf && gpr_data_reg == {28'h0, flag_data_reg})
        else $error("dual compare register and flags differ");
    chk_reg_cmp_flags: assert property (took(byte_compare_reg_op) |=>
        gpr_write_reg && flag_write_reg == 4'h0 && gpr_data_reg[31:4] == 28'h0)
        else $error("register compare touched flags");
    chk_half_cmp_eq: assert property (took(half_compare_flags_op) && req.cond == cmp_eq |=>
        flag_write_reg == 4'h3 && flag_data_reg[0] == ($past(req.src_a[15:0])
        == $past(req.src_b[15:0])) && flag_data_reg[3:2] == 2'b00)
        else $error("halfword compare flags wrong");
    chk_byte_lane_zero: assert property (took(byte_compare_flags_op) && req.cond == cmp_lt
        |=> flag_data_reg[0] == ($past(req.src_a[7:0]) < $past(req.src_b[7:0])))
        else $error("lane zero not on flag zero");
    chk_byte_sel_lane: assert property (took(byte_select_op) |=> gpr_data_reg[31:24]
        == ($past(flags_in[3]) ? $past(req.src_a[31:24]) : $past(req.src_b[31:24])))
        else $error("byte select lane three wrong");
    chk_half_sel_lane: assert property (took(half_select_op) |=> gpr_data_reg[15:0]
        == ($past(flags_in[0]) ? $past(req.src_a[15:0]) : $past(req.src_b[15:0])))
        else $error("halfword select lane zero wrong");
    chk_pack_halves: assert property (took(half_pack_op) |=> gpr_data_reg
        == {$past(req.src_a[15:0]), $past(req.src_b[31:16])})
        else $error("pack halves wrong");
    chk_shift_left_merge_op_zero: assert property (took(shift_left_merge_op) && req.shift_amount == 5'h0
        |=> gpr_data_reg == $past(req.src_b))
        else $error("shift_left_merge_op by zero must keep word");
    chk_shift_right_merge_op_top: assert property (took(shift_right_merge_op) && req.shift_amount == 5'h1
        |=> gpr_data_reg == {$past(req.src_a[0]), $past(req.src_b[31:1])})
        else $error("shift_right_merge_op by one wrong");
    chk_align_one: assert property (took(byte_align_op) && req.byte_count == 2'h1
        |=> gpr_data_reg == {$past(req.src_a[23:0]), $past(req.src_b[31:24])})
        else $error("byte align by one wrong");
    chk_repl_imm: assert property (took(half_replicate_imm_op) |=> gpr_data_reg
        == {2{{6{$past(req.imm[9])}}, $past(req.imm)}})
        else $error("halfword replicate wrong");
    chk_idle_quiet: assert property (!req_valid |=> !res_valid_reg && !gpr_write_reg
        && flag_write_reg == 4'h0)
        else $error("write without request");

    cov_dual_cmp: cover property (took(byte_compare_dual_op) ##1 took(byte_select_op));
    cov_half_cmp: cover property (took(half_compare_flags_op) ##1 took(half_select_op));
    cov_insert: cover property (took(variable_field_insert_op));
    cov_back_to_back: cover property (req_valid [*3]);

endmodule

//--- rtl/dbp_pkg.sv
// Purpose: Shared constants and types for the bit, compare and select datapath
// Assumes: 32-bit general registers, four byte lanes and two halfword lanes
// Notes: Compare flags travel as a separate 4-bit field beside the control word
package dbp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and lane layout
    localparam int DBP_WORD_W = 32;
    localparam int DBP_HALF_W = 16;
    localparam int DBP_BYTE_W = 8;
    localparam int DBP_IMM_W = 10;
    localparam int DBP_SHAMT_W = 5;
    localparam int DBP_BCNT_W = 2;
    localparam int DBP_BYTE_LANES = 4;
    localparam int DBP_HALF_LANES = 2;
    localparam int DBP_FLAG_W = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Control word fields used here
    localparam int DBP_CTRL_SIZE_LSB = 10;
    localparam int DBP_CTRL_SIZE_MSB = 14;
    localparam int DBP_CTRL_POS_LSB = 16;
    localparam int DBP_CTRL_POS_MSB = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Flag write masks and reset values
    localparam logic [DBP_FLAG_W-1:0] DBP_FLAGS_BYTE = 4'hf;
    localparam logic [DBP_FLAG_W-1:0] DBP_FLAGS_HALF = 4'h3;
    localparam logic [DBP_FLAG_W-1:0] DBP_FLAGS_NONE = 4'h0;
    localparam logic [DBP_WORD_W-1:0] DBP_WORD_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Operations
    typedef enum logic [3:0] {
        bit_reverse_op = 4'h0,
        variable_field_insert_op = 4'h1,
        byte_replicate_imm_op = 4'h2,
        byte_replicate_reg_op = 4'h3,
        half_replicate_imm_op = 4'h4,
        half_replicate_reg_op = 4'h5,
        byte_compare_flags_op = 4'h6,
        byte_compare_dual_op = 4'h7,
        byte_compare_reg_op = 4'h8,
        half_compare_flags_op = 4'h9,
        byte_select_op = 4'ha,
        half_select_op = 4'hb,
        shift_left_merge_op = 4'hc,
        shift_right_merge_op = 4'hd,
        byte_align_op = 4'he,
        half_pack_op = 4'hf
    } dbp_op_e;

    // Compare condition
    typedef enum logic [1:0] {
        cmp_eq = 2'h0,
        cmp_lt = 2'h1,
        cmp_le = 2'h2
    } dbp_cond_e;

    // One request from the core
    typedef struct packed {
        dbp_op_e op;
        dbp_cond_e cond;
        logic [DBP_WORD_W-1:0] src_a;
        logic [DBP_WORD_W-1:0] src_b;
        logic [DBP_IMM_W-1:0] imm;
        logic [DBP_SHAMT_W-1:0] shift_amount;
        logic [DBP_BCNT_W-1:0] byte_count;
    } dbp_req_s;

endpackage

//--- rtl/dbp_lane_cmp.sv
// Purpose: One lane comparator, equal, less-than or less-or-equal
// Assumes: Condition code is legal; an illegal code answers false
// Notes: Signedness is a parameter so byte and halfword lanes share it
`timescale 1ns/1ps
module dbp_lane_cmp
    import dbp_pkg::*;
#(
    parameter int LANE_W = 8,
    parameter bit IS_SIGNED = 1'b0
)
(
    // Operands
    input wire logic [LANE_W-1:0] lane_a,
    input wire logic [LANE_W-1:0] lane_b,
    // Condition
    input wire dbp_cond_e cond,
    // Result
    output logic hit
);

    logic lt; // Ordered less-than in the chosen signedness
    logic eq; // Bitwise equality

    ////////////////////////////////////////////////////////////////////////////
    // Compare in the lane's own signedness; the spare condition code never matches
    always_comb
    begin
        eq = (lane_a == lane_b);
        if (IS_SIGNED)
        begin
            lt = ($signed(lane_a) < $signed(lane_b));
        end
        else
        begin
            lt = (lane_a < lane_b);
        end
        unique case (cond)
            cmp_eq: hit = eq;
            cmp_lt: hit = lt;
            cmp_le: hit = lt | eq;
            default: hit = 1'b0; // Spare code never matches
        endcase
    end

endmodule

//--- sim/dbp_core_model.sv
// Purpose: Core-side compare flag register feeding the unit
// Assumes: Unit hands back a per-bit write mask and new flag data
// Notes: Flags clear on reset; the core owns them, not the unit
`timescale 1ns/1ps
module dbp_core_model
    import dbp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Flag update from the unit
    input wire logic [DBP_FLAG_W-1:0] flag_write,
    input wire logic [DBP_FLAG_W-1:0] flag_data,
    // Flags back to the unit
    output logic [DBP_FLAG_W-1:0] flags_reg
);
    ////////////////////////////////////////////////////////////////////////////
    // Masked merge; a request right after a compare still sees the old flags
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            flags_reg <= DBP_FLAGS_NONE;
        else
            flags_reg <= (flags_reg & ~flag_write) | (flag_data & flag_write);
    end
endmodule

//--- sim/testbench.sv
// Purpose: Self-checking bench for the bit, compare and select unit
// Assumes: Requests start at a falling edge, results read one cycle on
// Notes: Requests run back to back unless a task idles on purpose
`timescale 1ns/1ps
module testbench
    import dbp_pkg::*;
;
    logic ref_clk = 1'b0; // 100 ns core clock
    logic reset_n = 1'b0; // Low for the first 8 cycles
    logic req_valid = 1'b0;
    dbp_req_s req = '0;
    logic [31:0] dsp_ctrl_reg = 32'h0;
    logic [3:0] flags; // From the core model
    logic res_valid_reg, gpr_write_reg;
    logic [31:0] gpr_data_reg;
    logic [3:0] flag_write_reg, flag_data_reg;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    dbp_unit dbp_unit_inst (.ref_clk(ref_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req(req), .dsp_ctrl_reg(dsp_ctrl_reg), .flags_in(flags),
        .res_valid_reg(res_valid_reg), .gpr_write_reg(gpr_write_reg),
        .gpr_data_reg(gpr_data_reg), .flag_write_reg(flag_write_reg),
        .flag_data_reg(flag_data_reg));
    dbp_core_model dbp_core_model_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .flag_write(flag_write_reg), .flag_data(flag_data_reg), .flags_reg(flags));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the run needs under a hundred cycles
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic final_report();
    begin
        $display("Counts: %0d checks, %0d mismatches", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        n_tests++;
        if (exp !== got)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // Valid pulse, write enables and, when written, the word
    task automatic chk_res(input string what, input logic gw, input logic [31:0] d,
        input logic [3:0] fw);
    begin
        chk({what, " valid"}, 32'h1, {31'h0, res_valid_reg});
        chk({what, " gpr_write"}, {31'h0, gw}, {31'h0, gpr_write_reg});
        if (gw)
            chk({what, " data"}, d, gpr_data_reg);
        chk({what, " flag_write"}, {28'h0, fw}, {28'h0, flag_write_reg});
    end
    endtask
    // Leaves req_valid high so the next call runs back to back
    task automatic issue(input dbp_op_e op, input dbp_cond_e c, input logic [31:0] a, b,
        input logic [9:0] imm, input logic [4:0] sa, input logic [1:0] bc);
    begin
        req_valid = 1'b1;
        req = '{op, c, a, b, imm, sa, bc};
        @(negedge ref_clk);
    end
    endtask
    task automatic idle();
    begin
        req_valid = 1'b0;
        @(negedge ref_clk);
    end
    endtask
    // Lane compare; lane i lands in bit i, code 3 is never true
    function automatic logic [3:0] hits(input logic [31:0] a, b, input int c, input bit hf);
        logic [3:0] h;
        logic signed [16:0] x, y;
        h = 4'h0;
        for (int i = 0; i < (hf ? 2 : 4); i++)
        begin
            x = hf ? {a[16*i+15], a[16*i+:16]} : {9'h0, a[8*i+:8]};
            y = hf ? {b[16*i+15], b[16*i+:16]} : {9'h0, b[8*i+:8]};
            h[i] = (c == 0) ? (x == y) : (c == 1) ? (x < y) : (c == 2) ? (x <= y) : 1'b0;
        end
        return h;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_bits();
        logic [31:0] exp;
        logic [4:0] sz[4] = '{5'h08, 5'h08, 5'h00, 5'h1f};
        logic [4:0] ps[4] = '{5'h04, 5'h1c, 5'h05, 5'h01};
    begin
        exp = 32'h0;
        for (int i = 0; i < 16; i++)
            exp[i] = 32'hffff_1234 >> (15 - i);
        issue(bit_reverse_op, cmp_eq, 32'hffff_ffff, 32'hffff_1234, 10'h0, 5'h0, 2'h0);
        chk_res("bit_reverse_op", 1'b1, exp, 4'h0);
        // Field past bit 31 and size zero are the awkward cases
        foreach (sz[k])
        begin
            exp = 32'h1234_5678;
            for (int i = 0; i < 32; i++)
                if (i >= ps[k] && i < ps[k] + sz[k])
                    exp[i] = 32'hdead_beef >> (i - ps[k]);
            dsp_ctrl_reg = {11'h7ff, ps[k], 1'b1, sz[k], 10'h3ff};
            issue(variable_field_insert_op, cmp_eq, 32'hdead_beef, 32'h1234_5678,
                10'h0, 5'h1f, 2'h3);
            chk_res("insert", 1'b1, exp, 4'h0);
        end
        issue(byte_replicate_imm_op, cmp_eq, 32'h0, 32'h0, 10'h3a5, 5'h0, 2'h0);
        chk_res("repl byte imm", 1'b1, 32'ha5a5_a5a5, 4'h0);
        issue(byte_replicate_reg_op, cmp_eq, 32'h0, 32'h1234_5678, 10'h3ff, 5'h0, 2'h0);
        chk_res("repl byte reg", 1'b1, 32'h7878_7878, 4'h0);
        issue(half_replicate_imm_op, cmp_eq, 32'h0, 32'h0, 10'h200, 5'h0, 2'h0);
        chk_res("repl half imm", 1'b1, 32'hfe00_fe00, 4'h0);
        issue(half_replicate_reg_op, cmp_eq, 32'h0, 32'h1234_5678, 10'h1ff, 5'h0, 2'h0);
        chk_res("repl half reg", 1'b1, 32'h5678_5678, 4'h0);
        $display("done: bits");
    end
    endtask
    task automatic t_cmp();
        logic [3:0] h;
        dbp_op_e ops[3] = '{byte_compare_flags_op, byte_compare_dual_op, byte_compare_reg_op};
    begin
        for (int c = 0; c < 4; c++)
        begin
            h = hits(32'h0105_10ff, 32'h0205_0fff, c, 1'b0);
            for (int k = 0; k < 3; k++)
            begin
                issue(ops[k], dbp_cond_e'(c), 32'h0105_10ff, 32'h0205_0fff, 10'h0, 5'h0, 2'h0);
                chk_res("byte cmp", k != 0, {28'h0, h}, (k == 2) ? 4'h0 : 4'hf);
                if (k != 2)
                    chk("byte cmp flags", {28'h0, h}, {28'h0, flag_data_reg});
            end
        end
        // Lane 1 differs only when read as signed
        for (int c = 0; c < 3; c++)
        begin
            h = hits(32'h8000_0005, 32'h7fff_0005, c, 1'b1);
            issue(half_compare_flags_op, dbp_cond_e'(c), 32'h8000_0005, 32'h7fff_0005,
                10'h0, 5'h0, 2'h0);
            chk_res("half cmp", 1'b0, 32'h0, 4'h3);
            chk("half cmp flags", {30'h0, h[1:0]}, {30'h0, flag_data_reg[1:0]});
        end
        $display("done: compare");
    end
    endtask
    // Idle cycles let the core model take the new flags first
    task automatic t_select();
    begin
        issue(byte_compare_flags_op, cmp_eq, 32'h0105_10ff, 32'h0205_0fff, 10'h0, 5'h0, 2'h0);
        idle();
        issue(byte_select_op, cmp_eq, 32'h4433_2211, 32'hddcc_bbaa, 10'h0, 5'h0, 2'h0);
        chk_res("byte sel 5", 1'b1, 32'hdd33_bb11, 4'h0);
        issue(half_compare_flags_op, cmp_lt, 32'h8000_0005, 32'h7fff_0005, 10'h0, 5'h0, 2'h0);
        idle();
        issue(half_select_op, cmp_eq, 32'h4433_2211, 32'hddcc_bbaa, 10'h0, 5'h0, 2'h0);
        chk_res("half sel 6", 1'b1, 32'h4433_bbaa, 4'h0);
        issue(byte_select_op, cmp_eq, 32'h4433_2211, 32'hddcc_bbaa, 10'h0, 5'h0, 2'h0);
        chk_res("byte sel 6", 1'b1, 32'hdd33_22aa, 4'h0);
        $display("done: select");
    end
    endtask
    task automatic t_merge();
        logic [31:0] a = 32'ha3a2_a1a0;
        logic [31:0] b = 32'hb3b2_b1b0;
        logic [4:0] sas[4] = '{5'h00, 5'h01, 5'h08, 5'h1f};
        logic [31:0] m;
        int na, nb;
    begin
        foreach (sas[i])
        begin
            m = (32'h1 << sas[i]) - 32'h1;
            issue(shift_left_merge_op, cmp_eq, a, b, 10'h0, sas[i], 2'h0);
            chk_res("shift_left_merge_op", 1'b1, (b << sas[i]) | (a & m), 4'h0);
            issue(shift_right_merge_op, cmp_eq, a, b, 10'h0, sas[i], 2'h0);
            chk_res("shift_right_merge_op", 1'b1, (b >> sas[i]) | ((a & m) << (32 - sas[i])), 4'h0);
        end
        // Byte places are open; count bytes by their source nibble
        for (int bc = 0; bc < 4; bc++)
        begin
            issue(byte_align_op, cmp_eq, a, b, 10'h0, 5'h0, 2'(bc));
            na = 0;
            nb = 0;
            for (int j = 0; j < 4; j++)
            begin
                na += (gpr_data_reg[8*j+4+:4] === 4'ha);
                nb += (gpr_data_reg[8*j+4+:4] === 4'hb);
            end
            chk("byte_align_op write", 32'h1, {31'h0, gpr_write_reg});
            chk("byte_align_op bytes", bc * 16 + 4 - bc, nb * 16 + na);
        end
        $display("done: merge");
    end
    endtask
    task automatic t_pack_idle();
    begin
        issue(half_pack_op, cmp_eq, 32'h1111_2222, 32'h3333_4444, 10'h0, 5'h0, 2'h0);
        chk_res("pack", 1'b1, 32'h2222_3333, 4'h0);
        idle();
        chk("idle valid", 32'h0, {31'h0, res_valid_reg});
        chk("idle gpr_write", 32'h0, {31'h0, gpr_write_reg});
        chk("idle data", 32'h2222_3333, gpr_data_reg);
        // A second reset in mid-run clears the held word at once
        reset_n = 1'b0;
        #1;
        chk("reset data", 32'h0, gpr_data_reg);
        @(negedge ref_clk);
        reset_n = 1'b1;
        $display("done: pack and idle");
    end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        t_bits();
        t_cmp();
        t_select();
        t_merge();
        t_pack_idle();
        final_report();
    end
endmodule
